// File: ssm_unit.sv
// Signed subtract and multiply datapath for the built-in controller.
// Assumes operands and enable come from the sequencer on core_clk.
`timescale 1ns/1ns
`default_nettype none
module ssm_unit (
  input wire logic core_clk, // Core clock, 10 MHz
  input wire logic rst, // Async reset, active high
  input wire logic enable, // Instruction enable from sequencer
  input wire logic pulse_mode, // Pulse execution variant
  input wire logic double_mode, // 32-bit form when high
  input wire ssm_pkg::ssm_op_t op, // Subtract or multiply
  input wire logic [31:0] first_source, // Minuend or multiplicand
  input wire logic [31:0] second_source, // Subtrahend or multiplier
  output logic [31:0] dest_word, // Destination word (low pair)
  output logic [31:0] dest_next_word, // Next destination word(s)
  output logic dest_valid, // One-cycle write strobe
  output logic [7:0] step_count, // Program steps of the form
  output logic zero_flag, // Difference is zero
  output logic borrow_flag, // Below 16-bit range
  output logic carry_flag // Above 16-bit range
);
  // ----------------------------------------------------------------
  // Firing
  // ----------------------------------------------------------------
  logic fire;
  ssm_edge u_edge (
    .core_clk(core_clk),
    .rst(rst),
    .enable(enable),
    .pulse_mode(pulse_mode),
    .fire(fire)
  );

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  logic signed [32:0] diff16;
  logic signed [32:0] diff32;
  logic signed [31:0] prod16;
  logic signed [63:0] prod32;
  logic [31:0] next_dest_word;
  logic [31:0] next_dest_next_word;
  logic next_dest_valid;
  logic [7:0] next_step_count;
  logic next_zero;
  logic next_borrow;
  logic next_carry;

  always_comb begin
    // Sign extension makes the top bit the sign
    diff16 = 33'(signed'(first_source[15:0])) -
             33'(signed'(second_source[15:0]));
    diff32 = 33'(signed'(first_source)) -
             33'(signed'(second_source));
    prod16 = 32'(signed'(first_source[15:0])) *
             32'(signed'(second_source[15:0]));
    prod32 = 64'(signed'(first_source)) *
             64'(signed'(second_source));
    next_dest_word = dest_word;
    next_dest_next_word = dest_next_word;
    next_dest_valid = 1'b0;
    next_step_count = double_mode ? ssm_pkg::STEPS_DOUBLE_V
                                  : ssm_pkg::STEPS_SINGLE_V;
    next_zero = zero_flag;
    next_borrow = borrow_flag;
    next_carry = carry_flag;
    if (fire) begin
      next_dest_valid = 1'b1;
      if (op == ssm_pkg::ssm_subtract_op) begin
        if (double_mode) begin
          next_dest_word = diff32[31:0];
          next_zero = (diff32[31:0] == 32'h0000_0000);
          next_borrow = 1'b0;
          next_carry = 1'b0;
        end else begin
          next_dest_word = {{16{diff16[15]}}, diff16[15:0]};
          next_zero = (diff16[15:0] == 16'h0000);
          // Full-width difference below the most negative value
          next_borrow =
            (diff16 < 33'(signed'(ssm_pkg::MOST_NEG_16)));
          next_carry =
            (diff16 > 33'(signed'(ssm_pkg::MOST_POS_16)));
        end
      end else begin
        // Flags hold through a multiply
        if (double_mode) begin
          next_dest_word = prod32[31:0];
          next_dest_next_word = prod32[63:32];
        end else begin
          next_dest_word = {16'h0000, prod16[15:0]};
          next_dest_next_word = {16'h0000, prod16[31:16]};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dest_word <= ssm_pkg::DWORD_RESET;
      dest_next_word <= ssm_pkg::DWORD_RESET;
      dest_valid <= 1'b0;
      step_count <= ssm_pkg::STEPS_SINGLE_V;
      zero_flag <= 1'b0;
      borrow_flag <= 1'b0;
      carry_flag <= 1'b0;
    end else begin
      dest_word <= next_dest_word;
      dest_next_word <= next_dest_next_word;
      dest_valid <= next_dest_valid;
      step_count <= next_step_count;
      zero_flag <= next_zero;
      borrow_flag <= next_borrow;
      carry_flag <= next_carry;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sub_result: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_subtract_op && double_mode |=>
    dest_word == $past(first_source) - $past(second_source))
    else $error("subtract result wrong");
  a_sub_zero: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_subtract_op && !double_mode &&
    first_source[15:0] == second_source[15:0] |=> zero_flag)
    else $error("zero flag not set");
  a_sub_nonzero: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_subtract_op && !double_mode &&
    first_source[15:0] != second_source[15:0] |=> !zero_flag)
    else $error("zero flag set on nonzero difference");
  a_sub32_zero: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_subtract_op && double_mode &&
    first_source == second_source |=> zero_flag)
    else $error("double zero flag not set");
  a_sub_borrow: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_subtract_op && !double_mode &&
    first_source[15:0] == 16'h8000 && second_source[15:0] == 16'h0001
    |=> borrow_flag && !carry_flag)
    else $error("borrow flag not set");
  a_sub_carry: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_subtract_op && !double_mode &&
    first_source[15:0] == 16'h7fff && second_source[15:0] == 16'hffff
    |=> carry_flag && !borrow_flag)
    else $error("carry flag not set");
  a_sub32_flags: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_subtract_op && double_mode |=>
    !borrow_flag && !carry_flag)
    else $error("double subtract set a range flag");
  a_flags_apart: assert property (@(posedge core_clk) disable iff (rst)
    !(borrow_flag && carry_flag))
    else $error("borrow and carry both set");
  a_flags_idle: assert property (@(posedge core_clk) disable iff (rst)
    !fire |=> $stable(zero_flag) && $stable(borrow_flag) &&
    $stable(carry_flag))
    else $error("flags moved without execution");
  a_sub_sign: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_subtract_op && !double_mode |=>
    dest_word[31:16] == {16{dest_word[15]}})
    else $error("difference not sign extended");
  a_next_hold: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_subtract_op |=> $stable(dest_next_word))
    else $error("subtract changed next word");
  a_step_count: assert property (@(posedge core_clk) disable iff (rst)
    double_mode |=> step_count == 8'h0d)
    else $error("step count wrong");
  a_step_single: assert property (@(posedge core_clk) disable iff (rst)
    !double_mode |=> step_count == 8'h07)
    else $error("single step count wrong");
  a_pulse_once: assert property (@(posedge core_clk) disable iff (rst)
    pulse_mode && enable && $past(enable) |=> !dest_valid)
    else $error("pulse fired twice");
  a_cont_fire: assert property (@(posedge core_clk) disable iff (rst)
    !pulse_mode && enable |=> dest_valid)
    else $error("continuous did not fire");
  a_valid_only: assert property (@(posedge core_clk) disable iff (rst)
    !fire |=> !dest_valid)
    else $error("write strobe without execution");
  a_mul_split: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_multiply_op && !double_mode &&
    first_source[15:0] == 16'h7fff && second_source[15:0] == 16'h7fff |=>
    {dest_next_word[15:0], dest_word[15:0]} == 32'h3fff_0001)
    else $error("product halves wrong");
  a_mul_neg: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_multiply_op && !double_mode &&
    first_source[15:0] == 16'hfffd && second_source[15:0] == 16'h0007
    |=> dest_next_word[15:0] == 16'hffff &&
    dest_word[15:0] == 16'hffeb)
    else $error("negative product wrong");
  a_mul_double: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_multiply_op && double_mode &&
    first_source == 32'hffff_fffe && second_source == 32'h0000_0003
    |=> dest_next_word == 32'hffff_ffff &&
    dest_word == 32'hffff_fffa)
    else $error("double product wrong");
  a_mul_upper: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_multiply_op && !double_mode |=>
    dest_word[31:16] == 16'h0000 &&
    dest_next_word[31:16] == 16'h0000)
    else $error("product upper bits set");
  a_mul_flags: assert property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_multiply_op |=>
    $stable(zero_flag) && $stable(borrow_flag) &&
    $stable(carry_flag))
    else $error("multiply changed flags");

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  c_sub_fire: cover property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_subtract_op);
  c_mul_double: cover property (@(posedge core_clk) disable iff (rst)
    fire && op == ssm_pkg::ssm_multiply_op && double_mode);
  c_borrow: cover property (@(posedge core_clk) disable iff (rst)
    $rose(borrow_flag));
  c_carry: cover property (@(posedge core_clk) disable iff (rst)
    $rose(carry_flag));
  c_pulse_fire: cover property (@(posedge core_clk) disable iff (rst)
    fire && pulse_mode);
endmodule // ssm_unit
`default_nettype wire

// File: ssm_pkg.sv
// Constants and types for the signed subtract and multiply unit.
// Assumes a single core clock; widths are in bits.
`default_nettype none
package ssm_pkg;
  localparam int WORD_W = 16;
  localparam int DWORD_W = 32;
  localparam int STEPS_SINGLE = 7;
  localparam int STEPS_DOUBLE = 13;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [DWORD_W-1:0] DWORD_RESET = 32'h0000_0000;
  localparam logic [7:0] STEPS_SINGLE_V = 8'h07;
  localparam logic [7:0] STEPS_DOUBLE_V = 8'h0d;
  localparam logic [15:0] MOST_NEG_16 = 16'h8000;
  localparam logic [15:0] MOST_POS_16 = 16'h7fff;

  typedef enum logic [1:0] {
    ssm_subtract_op,
    ssm_multiply_op
  } ssm_op_t;
endpackage
`default_nettype wire

// File: ssm_edge.sv
// Enable stage: continuous or pulse firing for one instruction slot.
// Assumes enable comes from the sequencer on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ssm_edge (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic enable, // Instruction enable level
  input wire logic pulse_mode, // High for pulse variant
  output logic fire // Execute this cycle
);
  logic prev;
  logic next_prev;

  always_comb begin
    next_prev = enable;
    fire = enable & (~pulse_mode | ~prev);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prev <= 1'b0;
    end else begin
      prev <= next_prev;
    end
  end
endmodule // ssm_edge
`default_nettype wire

// File: ssm_mem_model.sv
// Destination memory model behind the unit.
// Assumes write strobes arrive on core_clk.
`timescale 1ns/1ns
`default_nettype none
module ssm_mem_model (
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, active high
  input wire logic wr, // Write strobe
  input wire logic [31:0] lo, // Word at destination
  output var logic [31:0] mem_lo, // Stored destination word
  output var int writes // Writes taken
);
  // Counts every strobe so repeated firing cannot hide
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_lo <= 32'h0000_0000;
      writes <= 0;
    end else if (wr) begin
      mem_lo <= lo;
      writes <= writes + 1;
    end
  end
endmodule // ssm_mem_model
`default_nettype wire

// File: ssm_unit_tb_top.sv
// Self-checking bench for the signed subtract and multiply unit.
// Assumes the memory model sits on the destination side.
`timescale 1ns/1ns
`default_nettype none
module ssm_unit_tb_top;
  logic core_clk, rst, enable, pulse_mode, double_mode, dv, zf, bf, cf;
  ssm_pkg::ssm_op_t op;
  logic [31:0] a, b, dw, dn, mlo, en;
  logic [7:0] sc;
  logic ez, eb, ec;
  logic signed [63:0] p;
  int writes, failures, samples_checked, cyc;
  ssm_unit i_dut (.core_clk(core_clk), .rst(rst), .enable(enable),
    .pulse_mode(pulse_mode), .double_mode(double_mode), .op(op),
    .first_source(a), .second_source(b), .dest_word(dw),
    .dest_next_word(dn), .dest_valid(dv), .step_count(sc),
    .zero_flag(zf), .borrow_flag(bf), .carry_flag(cf));
  ssm_mem_model i_mem (.core_clk(core_clk), .rst(rst), .wr(dv), .lo(dw),
    .mem_lo(mlo), .writes(writes));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Enable held four scans; pulse must fire once only
  task automatic pulse_hold(input logic pm);
    int n;
    n = writes;
    @(negedge core_clk);
    pulse_mode = pm;
    a = 32'h9;
    b = 32'h2;
    enable = 1'b1;
    repeat (4) @(negedge core_clk);
    enable = 1'b0;
    @(negedge core_clk);
    check(writes - n, pm ? 64'h1 : 64'h4);
    check(mlo, 32'h7);
    pulse_mode = 1'b0;
  endtask
  task automatic exec(input ssm_pkg::ssm_op_t o, input logic dbl,
      input logic [31:0] x, input logic [31:0] y);
    @(negedge core_clk);
    op = o;
    double_mode = dbl;
    a = x;
    b = y;
    enable = 1'b1;
    @(negedge core_clk);
    enable = 1'b0;
    check(dv, 1'b1);
    if (o == ssm_pkg::ssm_subtract_op && !dbl) begin
      p = $signed(x[15:0]) - $signed(y[15:0]);
      ez = (p == 64'h0);
      eb = (p < 64'shffff_ffff_ffff_8000);
      ec = (p > 64'sh0000_0000_0000_7fff);
      check(dw, {{16{p[15]}}, p[15:0]});
    end else if (o == ssm_pkg::ssm_subtract_op) begin
      p = x - y;
      ez = (p[31:0] == 32'h0);
      eb = 1'b0;
      ec = 1'b0;
      check(dw, p[31:0]);
    end else begin
      p = dbl ? $signed(x) * $signed(y) : $signed(x[15:0]) * $signed(y[15:0]);
      en = dbl ? p[63:32] : {16'h0, p[31:16]};
      check(dw, dbl ? p[31:0] : {16'h0, p[15:0]});
    end
    // Subtract must leave the next word as the last product left it
    check(dn, en);
    check({zf, bf, cf}, {ez, eb, ec});
    check(sc, dbl ? 8'h0d : 8'h07);
  endtask
  initial begin
    {rst, ez, eb, ec} = 4'h8;
    {enable, pulse_mode, double_mode} = 3'h0;
    op = ssm_pkg::ssm_subtract_op;
    a = 32'h0;
    b = 32'h0;
    en = 32'h0;
    failures = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
    check(sc, 8'h07);
    pulse_hold(1'b1);
    pulse_hold(1'b0);
    exec(ssm_pkg::ssm_subtract_op, 1'b0, 32'h5, 32'h5);
    exec(ssm_pkg::ssm_multiply_op, 1'b0, 32'hfffd, 32'h7);
    exec(ssm_pkg::ssm_subtract_op, 1'b0, 32'h8000, 32'h1);
    exec(ssm_pkg::ssm_multiply_op, 1'b0, 32'h7fff, 32'h7fff);
    exec(ssm_pkg::ssm_subtract_op, 1'b0, 32'h7fff, 32'hffff);
    exec(ssm_pkg::ssm_multiply_op, 1'b1, 32'hffff_fffe, 32'h3);
    exec(ssm_pkg::ssm_subtract_op, 1'b0, 32'h3, 32'h5);
    exec(ssm_pkg::ssm_subtract_op, 1'b1, 32'h1234_5678, 32'h1234_5678);
    exec(ssm_pkg::ssm_subtract_op, 1'b1, 32'h1, 32'h2);
    final_report();
  end
  always @(posedge core_clk) begin
    cyc++;
    // Run needs about 36 cycles
    if (cyc > 32'h190) begin
      failures++;
      final_report();
    end
  end
endmodule // ssm_unit_tb_top
`default_nettype wire
